/* File: rtl/dtce_defs.vh */
/*
  constants for the die temperature command engine: register offsets,
  status layout, key bytes, command codes, status codes, timing counts.
  assumes it is included by bare name from the rtl files.
*/
`ifndef DTCE_DEFS_VH
`define DTCE_DEFS_VH

// apb byte offsets
`define DTCE_OFF_CPU_DATA    12'h000
`define DTCE_OFF_DMA_DATA    12'h004
`define DTCE_OFF_STATUS      12'h008
`define DTCE_OFF_SENSOR_CFG  12'h00c
`define DTCE_OFF_SEQ_CTRL    12'h010

// status register fields
`define DTCE_SR_READY_BIT    0
`define DTCE_SR_IDLE_BIT     1
`define DTCE_SR_CODE_LSB     2

// key bytes
`define DTCE_KEY1            8'hb6
`define DTCE_KEY2_BASE       8'hd3

// command codes
`define DTCE_CMD_GET_TEMP    8'h0e
`define DTCE_CMD_SETUP       8'h11
`define DTCE_CMD_DISABLE     8'h12

// status codes
`define DTCE_ST_OK           6'h00
`define DTCE_ST_BAD_KEY      6'h02
`define DTCE_ST_BAD_CMD      6'h0b
`define DTCE_ST_BAD_PARAM    6'h0d
`define DTCE_ST_ROUTED       6'h0e

// averaging limits
`define DTCE_MAX_EXP         8'h05

// cycles per converter sample
`define DTCE_SAMPLE_CYCLES   8'h10

// reset values
`define DTCE_RST_STATUS      8'h02

`endif

/* File: rtl/dtce_seq_div.v */
/*
  element-matching sequencer clock divider and mirror path counter.
  assumes pclk stands in for the controller clock; the tick rate is
  pclk / (divisor + 1), and the path index advances once per tick.
*/
`timescale 1ns/1ps
module dtce_seq_div
(
  input  wire       pclk,
  input  wire       presetn,
  input  wire       run,
  input  wire       freeze,
  input  wire [7:0] divisor,
  output reg        seq_tick,
  output reg  [2:0] mirror_path
);

  reg [7:0] cnt_q; // divider count

  // divider: tick every divisor+1 cycles, held off when stopped
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q       <= 8'h00;
      seq_tick    <= 1'b0;
      mirror_path <= 3'h0;
    end
    else if (!run || freeze)
    begin
      // frozen: no cycling, path held
      cnt_q    <= 8'h00;
      seq_tick <= 1'b0;
    end
    else if (cnt_q >= divisor)
    begin
      cnt_q       <= 8'h00;
      seq_tick    <= 1'b1;
      mirror_path <= mirror_path + 3'h1; // eight paths wrap
    end
    else
    begin
      cnt_q    <= cnt_q + 8'h01;
      seq_tick <= 1'b0;
    end
  end

endmodule // dtce_seq_div

/* File: rtl/dtce_engine.v */
/*
  apb slave holding the cpu and dma command ports and the status
  register, with the command interpreter for the temperature sensor.
  assumes a 32-bit apb master on pclk; converter samples arrive on
  adc_data with adc_valid as a same-clock one-cycle pulse.
*/
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "dtce_defs.vh"

// Overview of operation
// - every command starts with key 0xb6
// - second key is 0xd3 plus command
// - idle clears on key1, sets on end
// - bytes written while busy are ignored
// - answer through port that took command
// - bad key or param: no execute, report
// - status code bits 7:2, defined values
// - report 0x0e while output routed out
// - get temp returns sign then magnitude
// - exponent 0..5 averages up to 32 samples
// - ready set per byte, cleared on read
// - setup routes sensor, stops converter
// - bias select picks low or high current
// - freeze stops sequencer cycling
// - sequencer clock is divisor plus one
// - curvature compensation on when one
// - disable command frees analog line
module dtce_engine
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [9:0]  adc_data,
  input  wire        adc_valid,
  output reg         adc_enable,
  output reg         sensor_routed,
  output reg         bias_high,
  output reg         curv_comp_en,
  output wire        seq_tick,
  output wire [2:0]  mirror_path
);

  // state codes
  localparam [3:0] S_IDLE   = 4'h0; // waiting for key1
  localparam [3:0] S_KEY2   = 4'h1; // expecting second key
  localparam [3:0] S_CODE   = 4'h2; // expecting command code
  localparam [3:0] S_P_EXP  = 4'h3; // get temp exponent
  localparam [3:0] S_P_BIAS = 4'h4; // setup bias select
  localparam [3:0] S_P_FRZ  = 4'h5; // setup freeze
  localparam [3:0] S_P_DIV  = 4'h6; // setup divisor
  localparam [3:0] S_P_CURV = 4'h7; // setup curvature
  localparam [3:0] S_CONV   = 4'h8; // sampling
  localparam [3:0] S_SIGN   = 4'h9; // sign byte waiting
  localparam [3:0] S_MAG    = 4'ha; // magnitude byte waiting

  reg [3:0]  state_q;        // interpreter state
  reg [7:0]  key2_q;         // captured second key
  reg        port_dma_q;     // command came in on dma port
  reg [5:0]  code_q;         // status code field
  reg        ready_q;        // result-ready flag
  reg [7:0]  out_byte_q;     // response byte
  reg [2:0]  exp_q;          // sample count exponent
  reg [5:0]  samp_left_q;    // samples still to take
  reg [15:0] acc_q;          // sample accumulator
  reg [7:0]  mag_q;          // averaged magnitude
  reg        frz_q;          // sequencer freeze
  reg [7:0]  div_q;          // sequencer divisor
  reg        bias_p_q;       // pending bias select
  reg        frz_p_q;        // pending freeze
  reg [7:0]  div_p_q;        // pending divisor
  reg        offset_sign_q;  // sw: result sign when no offset

  wire idle = (state_q == S_IDLE);

  // apb decode; zero wait, never errors
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & penable & ~pwrite;

  wire hit_cpu = (paddr == `DTCE_OFF_CPU_DATA);
  wire hit_dma = (paddr == `DTCE_OFF_DMA_DATA);
  wire byte_wr = wr_acc & (hit_cpu | hit_dma);
  wire [7:0] wb = pwdata[7:0];

  // reading the port that owns the command consumes the byte
  wire own_rd = rd_acc & ready_q &
                ((hit_cpu & ~port_dma_q) | (hit_dma & port_dma_q));

  // key check against the command code
  // carry out of the key sum is dropped on purpose
  wire [8:0] key_sum  = {1'b0, `DTCE_KEY2_BASE} + {1'b0, wb};
  wire [7:0] key_want = key_sum[7:0];

  wire [7:0] status_byte = {code_q, idle, ready_q};

  // averaged value: shift by exponent, 0 skips averaging
  wire [15:0] avg = acc_q >> exp_q;

  // read data mux
  always @*
  begin
    prdata = 32'h0000_0000; // unmapped reads zero
    if ((hit_cpu && !port_dma_q) || (hit_dma && port_dma_q))
    begin
      prdata[7:0] = out_byte_q;
    end
    else if (paddr == `DTCE_OFF_STATUS)
    begin
      prdata[7:0] = status_byte;
    end
    else if (paddr == `DTCE_OFF_SENSOR_CFG)
    begin
      prdata[3:0] = {offset_sign_q, curv_comp_en, bias_high,
                     sensor_routed};
    end
    else if (paddr == `DTCE_OFF_SEQ_CTRL)
    begin
      prdata[11:0] = {mirror_path, frz_q, div_q};
    end
  end

  // sign configuration written by software
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      offset_sign_q <= 1'b1;
    end
    else if (wr_acc && paddr == `DTCE_OFF_SENSOR_CFG)
    begin
      offset_sign_q <= pwdata[3];
    end
  end

  // command interpreter
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q       <= S_IDLE;
      key2_q        <= 8'h00;
      port_dma_q    <= 1'b0;
      code_q        <= `DTCE_ST_OK;
      ready_q       <= 1'b0;
      out_byte_q    <= 8'h00;
      exp_q         <= 3'h0;
      samp_left_q   <= 6'h00;
      acc_q         <= 16'h0000;
      mag_q         <= 8'h00;
      frz_q         <= 1'b1;
      div_q         <= 8'h00;
      bias_p_q      <= 1'b0;
      frz_p_q       <= 1'b0;
      div_p_q       <= 8'h00;
      adc_enable    <= 1'b1;
      sensor_routed <= 1'b0;
      bias_high     <= 1'b0;
      curv_comp_en  <= 1'b0;
    end
    else
    begin
      case (state_q)
        S_IDLE:
        begin
          // only key1 opens a command; code holds until then
          if (byte_wr && wb == `DTCE_KEY1)
          begin
            state_q    <= S_KEY2;
            port_dma_q <= hit_dma;
            code_q     <= `DTCE_ST_OK;
          end
        end
        S_KEY2:
        begin
          if (byte_wr)
          begin
            key2_q  <= wb;
            state_q <= S_CODE;
          end
        end
        S_CODE:
        begin
          if (byte_wr)
          begin
            if (key2_q != key_want)
            begin
              code_q  <= `DTCE_ST_BAD_KEY;
              state_q <= S_IDLE;
            end
            else if (wb == `DTCE_CMD_GET_TEMP)
            begin
              state_q <= S_P_EXP;
            end
            else if (wb == `DTCE_CMD_SETUP)
            begin
              state_q <= S_P_BIAS;
            end
            else if (wb == `DTCE_CMD_DISABLE)
            begin
              // no parameters, frees line, restarts converter
              sensor_routed <= 1'b0;
              adc_enable    <= 1'b1;
              curv_comp_en  <= 1'b0;
              code_q        <= `DTCE_ST_OK;
              state_q       <= S_IDLE;
            end
            else
            begin
              code_q  <= `DTCE_ST_BAD_CMD;
              state_q <= S_IDLE;
            end
          end
        end
        S_P_EXP:
        begin
          if (byte_wr)
          begin
            if (wb > `DTCE_MAX_EXP)
            begin
              code_q  <= `DTCE_ST_BAD_PARAM;
              state_q <= S_IDLE;
            end
            else if (sensor_routed)
            begin
              code_q  <= `DTCE_ST_ROUTED;
              state_q <= S_IDLE;
            end
            else
            begin
              exp_q       <= wb[2:0];
              samp_left_q <= 6'h01 << wb[2:0];
              acc_q       <= 16'h0000;
              state_q     <= S_CONV;
            end
          end
        end
        S_P_BIAS:
        begin
          if (byte_wr)
          begin
            bias_p_q <= wb[0];
            state_q  <= (wb > 8'h01) ? S_IDLE : S_P_FRZ;
            if (wb > 8'h01)
            begin
              code_q <= `DTCE_ST_BAD_PARAM;
            end
          end
        end
        S_P_FRZ:
        begin
          if (byte_wr)
          begin
            frz_p_q <= wb[0];
            state_q <= (wb > 8'h01) ? S_IDLE : S_P_DIV;
            if (wb > 8'h01)
            begin
              code_q <= `DTCE_ST_BAD_PARAM;
            end
          end
        end
        S_P_DIV:
        begin
          // any 8-bit divisor is valid
          if (byte_wr)
          begin
            div_p_q <= wb;
            state_q <= S_P_CURV;
          end
        end
        S_P_CURV:
        begin
          if (byte_wr)
          begin
            state_q <= S_IDLE;
            if (wb > 8'h01)
            begin
              code_q <= `DTCE_ST_BAD_PARAM;
            end
            else
            begin
              // settings only commit once all parameters pass
              sensor_routed <= 1'b1;
              adc_enable    <= 1'b0;
              bias_high     <= bias_p_q;
              frz_q         <= frz_p_q;
              div_q         <= div_p_q;
              curv_comp_en  <= wb[0];
              code_q        <= `DTCE_ST_OK;
            end
          end
        end
        S_CONV:
        begin
          // accumulate converter samples, top 8 bits used
          if (adc_valid)
          begin
            acc_q       <= acc_q + {6'h00, adc_data};
            samp_left_q <= samp_left_q - 6'h01;
            if (samp_left_q == 6'h01)
            begin
              state_q <= S_SIGN;
            end
          end
        end
        S_SIGN:
        begin
          // first cycle: present sign byte and raise ready
          if (!ready_q)
          begin
            mag_q      <= avg[9:2];
            out_byte_q <= {7'h00, offset_sign_q};
            ready_q    <= 1'b1;
          end
          else if (own_rd)
          begin
            ready_q <= 1'b0;
            state_q <= S_MAG;
          end
        end
        S_MAG:
        begin
          if (!ready_q)
          begin
            out_byte_q <= mag_q;
            ready_q    <= 1'b1;
          end
          else if (own_rd)
          begin
            ready_q <= 1'b0;
            code_q  <= `DTCE_ST_OK;
            state_q <= S_IDLE;
          end
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
      // writes while busy fall through each state untouched
    end
  end

  // sequencer runs only while the sensor is routed out
  dtce_seq_div u_seq
  (
    .pclk        (pclk),
    .presetn     (presetn),
    .run         (sensor_routed),
    .freeze      (frz_q),
    .divisor     (div_q),
    .seq_tick    (seq_tick),
    .mirror_path (mirror_path)
  );

endmodule // dtce_engine

/* File: bench/dtce_adc_model.sv */
/*
  aux converter model: 10-bit samples at random spacing.
  assumes go from the bench and adc_enable from the engine.
*/
`timescale 1ns/1ps
module dtce_adc_model
(
  input  wire       pclk,
  input  wire       go,
  input  wire       adc_enable,
  output reg  [9:0] adc_data,
  output reg        adc_valid
);
  integer gap; // idle cycles before next sample

  initial
  begin
    adc_data  = 10'h000;
    adc_valid = 1'b0;
    gap       = 1;
  end

  // one-cycle pulse per sample, prompt or slow
  always @(posedge pclk)
  begin
    adc_valid <= 1'b0;
    adc_data  <= ~adc_data; // no stale value between samples
    if (go && adc_enable && gap == 0)
    begin
      adc_valid <= 1'b1;
      adc_data  <= $urandom % 1024;
      gap       <= $urandom % 4;
    end
    else if (gap > 0)
      gap <= gap - 1;
  end
endmodule // dtce_adc_model

/* File: bench/dtce_engine_asserts.sv */
/*
  port checker for the temperature command engine.
  assumes it is bound onto dtce_engine, one clock pclk.
*/
`timescale 1ns/1ps
module dtce_engine_asserts
(
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        adc_enable,
  input wire        sensor_routed,
  input wire        bias_high,
  input wire        curv_comp_en,
  input wire        seq_tick,
  input wire [2:0]  mirror_path
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // bias, compensation and routing outputs only move in reply to a completed write
  wire wr_acc = psel && penable && pwrite;
  wire sr_rd  = psel && !pwrite && paddr == 12'h008;

  property p_ready; pready && !pslverr; endproperty
  a_ready: assert property (p_ready)
    else $error("bus answer not immediate");
  property p_route_adc; sensor_routed |-> !adc_enable; endproperty
  a_route_adc: assert property (p_route_adc)
    else $error("converter on while routed");
  // the divider's tick is a flop fed by last cycle's routing state
  property p_tick_routed; seq_tick |-> $past(sensor_routed); endproperty
  a_tick_routed: assert property (p_tick_routed)
    else $error("sequencer ticks while not routed");
  property p_path_step;
    $changed(mirror_path) |-> mirror_path == $past(mirror_path) + 3'd1;
  endproperty
  a_path_step: assert property (p_path_step)
    else $error("mirror path skipped");
  property p_path_cause;
    $changed(mirror_path) |-> seq_tick || $past(seq_tick);
  endproperty
  a_path_cause: assert property (p_path_cause)
    else $error("mirror path moved without tick");
  property p_bias_src; $changed(bias_high) |-> $past(wr_acc); endproperty
  a_bias_src: assert property (p_bias_src)
    else $error("bias changed without a write");
  property p_curv_src; $changed(curv_comp_en) |-> $past(wr_acc); endproperty
  a_curv_src: assert property (p_curv_src)
    else $error("compensation changed without a write");
  property p_route_src; $changed(sensor_routed) |-> $past(wr_acc); endproperty
  a_route_src: assert property (p_route_src)
    else $error("routing changed without a write");
  property p_sr_fmt;
    sr_rd |-> prdata[31:8] == 24'h0 && !(prdata[1] && prdata[0]);
  endproperty
  a_sr_fmt: assert property (p_sr_fmt)
    else $error("status read malformed");

  c_route: cover property ($rose(sensor_routed));
  c_tick: cover property (seq_tick);
  c_ready: cover property (sr_rd && prdata[0]);
endmodule // dtce_engine_asserts

bind dtce_engine dtce_engine_asserts u_dtce_engine_asserts
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .adc_enable, .sensor_routed, .bias_high, .curv_comp_en,
  .seq_tick, .mirror_path
);

/* File: bench/tb.sv */
/*
  self-checking bench for the command engine: apb master, expected
  values from a running sample sum. assumes the converter model.
*/
`timescale 1ns/1ps
`include "dtce_defs.vh"
module tb;
  reg         pclk, presetn, psel, penable, pwrite, go;
  reg  [11:0] paddr, p, q;
  reg  [31:0] pwdata, rd, x;
  reg  [7:0]  b, c, d;
  wire [31:0] prdata;
  wire        pready, pslverr, adc_valid, adc_enable, sensor_routed;
  wire        bias_high, curv_comp_en, seq_tick;
  wire [9:0]  adc_data;
  wire [2:0]  mirror_path;
  integer     bad_count, check_count, need, nsmp, sum, e, i, k, t;
  localparam [11:0] o_cpu = `DTCE_OFF_CPU_DATA;
  localparam [11:0] o_dma = `DTCE_OFF_DMA_DATA;
  localparam [11:0] o_sr  = `DTCE_OFF_STATUS;
  localparam [11:0] o_cfg = `DTCE_OFF_SENSOR_CFG;

  dtce_engine u_dtce_engine
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .adc_data, .adc_valid, .adc_enable, .sensor_routed,
    .bias_high, .curv_comp_en, .seq_tick, .mirror_path
  );
  dtce_adc_model u_dtce_adc_model
  (
    .pclk, .go, .adc_enable, .adc_data, .adc_valid
  );

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // reference model: sum the samples the engine must average
  always @(posedge pclk)
    if (adc_valid && nsmp < need)
    begin
      sum  = sum + adc_data;
      nsmp = nsmp + 1;
    end

  task summarize;
  begin
    $display("mismatches %0d checks %0d", bad_count, check_count);
    if (bad_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask

  task chk(input [31:0] g, input [31:0] xv);
  begin
    check_count = check_count + 1;
    if (g !== xv)
    begin
      bad_count = bad_count + 1;
      $display("[ERR] %0t got %h exp %h", $time, g, xv);
    end
  end
  endtask

  // one apb transfer; read data taken at the pready edge
  task xfer(input w, input [11:0] a, input [31:0] wd);
    integer n;
  begin
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n = n + 1; end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    if (n >= 20)
    begin
      bad_count = bad_count + 1;
      summarize;
    end
    psel <= 1'b0; penable <= 1'b0;
  end
  endtask

  task rdc(input [11:0] a, input [31:0] xv);
  begin
    xfer(1'b0, a, 32'h0);
    chk(rd, xv);
  end
  endtask

  // keys, code, then parameter bytes low first
  task cmd(input [11:0] pt, input [7:0] k2, input [7:0] cc,
           input integer np, input [31:0] prm);
    integer j;
  begin
    xfer(1'b0, o_sr, 32'h0);
    chk(rd[1], 1'b1);
    xfer(1'b1, pt, 32'hb6);
    rdc(o_sr, 32'h00);
    xfer(1'b1, pt, {24'h0, k2});
    xfer(1'b1, pt, {24'h0, cc});
    for (j = 0; j < np; j = j + 1)
      xfer(1'b1, pt, {24'h0, prm[8*j +: 8]});
  end
  endtask

  // host waits for the ready flag, bounded
  task poll;
  begin
    rd = 32'h0;
    for (t = 0; t < 500 && rd[0] !== 1'b1; t = t + 1)
      xfer(1'b0, o_sr, 32'h0);
    if (t >= 500)
    begin
      bad_count = bad_count + 1;
      summarize;
    end
  end
  endtask

  task twait;
  begin
    t = 0;
    do begin @(posedge pclk); t = t + 1; end
    while (seq_tick !== 1'b1 && t < 40);
  end
  endtask

  initial
  begin
    repeat (100000) @(posedge pclk);
    bad_count = bad_count + 1;
    summarize;
  end

  initial
  begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; go = 0;
    presetn = 0; bad_count = 0; check_count = 0; need = 0; nsmp = 0;
    sum = 0;
    k = $urandom(32'h9d56);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(o_sr, 32'h02);
    rdc(12'hffc, 32'h0);
    // every exponent, ports alternating, sign value varied
    for (e = 0; e < 6; e = e + 1)
    begin
      p = e[0] ? o_dma : o_cpu;
      q = e[0] ? o_cpu : o_dma;
      xfer(1'b1, o_cfg, {28'h0, e[1], 3'h0});
      need = 1 << e; nsmp = 0; sum = 0;
      cmd(p, 8'he1, 8'h0e, 1, e);
      xfer(1'b1, q, 32'hb6);
      go <= 1'b1;
      poll;
      go <= 1'b0;
      chk(nsmp, need);
      rdc(o_sr, 32'h01);
      rdc(q, 32'h0);
      rdc(p, e[1]);
      poll;
      rdc(p, sum >> (e + 2));
      rdc(o_sr, 32'h02);
    end
    // refused commands and their codes
    for (i = 0; i < 4; i = i + 1)
    begin
      case (i)
        0: begin cmd(o_cpu, 8'h00, 8'h0e, 0, 0); x = 32'h0a; end
        1: begin cmd(o_cpu, 8'hd8, 8'h05, 0, 0); x = 32'h2e; end
        2: begin cmd(o_dma, 8'he1, 8'h0e, 1, 6); x = 32'h36; end
        default: begin cmd(o_cpu, 8'he4, 8'h11, 1, 2); x = 32'h36; end
      endcase
      rdc(o_sr, x);
    end
    // routing with sequencer free and frozen
    for (k = 0; k < 2; k = k + 1)
    begin
      b = $urandom % 2; c = $urandom % 2; d = $urandom % 4;
      cmd(o_cpu, 8'he4, 8'h11, 4, {c, d, k[7:0], b});
      rdc(o_sr, 32'h02);
      rdc(o_cfg, {29'h0, c[0], b[0], 1'b1});
      chk(adc_enable, 1'b0);
      chk(bias_high, b[0]);
      chk(curv_comp_en, c[0]);
      twait;
      if (k == 1)
        chk(t, 40);
      else
      begin
        twait;
        chk(t, d + 1);
      end
      cmd(o_dma, 8'he1, 8'h0e, 1, 0);
      rdc(o_sr, 32'h3a);
      cmd(o_cpu, 8'he5, 8'h12, 0, 0);
      rdc(o_sr, 32'h02);
      chk(sensor_routed, 1'b0);
    end
    summarize;
  end
endmodule // tb
